// *** design/mic_consts.svh ***
/*
 Constants of the interrupt controller: register indices,
 bit positions, write masks, vectors and event indices.
 Assumes inclusion by name from the package and the module.
*/
`ifndef MIC_CONSTS_SVH
`define MIC_CONSTS_SVH
`define MIC_PCW 13
`define MIC_NEV 12
`define MIC_R_INTC0 4'h0
`define MIC_R_INTC1 4'h1
`define MIC_R_CTL2 4'h2
`define MIC_R_SHS0 4'h3
`define MIC_R_SHS1 4'h4
`define MIC_R_SHS2 4'h5
`define MIC_R_EDGE 4'h6
`define MIC_R_PCFG 4'h7
`define MIC_R_STAT 4'h8
`define MIC_M_INTC0 8'h7f
`define MIC_M_FULL 8'hff
`define MIC_M_MFI 8'h33
`define MIC_M_LOW 8'h0f
`define MIC_B_GIE 0
`define MIC_B_INT0E 1
`define MIC_B_MF0E 3
`define MIC_B_INT0F 4
`define MIC_B_MF0F 6
`define MIC_B_MF1E 0
`define MIC_B_MF2E 1
`define MIC_B_ADE 2
`define MIC_B_TB0E 3
`define MIC_B_MF1F 4
`define MIC_B_MF2F 5
`define MIC_B_ADF 6
`define MIC_B_TB0F 7
`define MIC_B_TBE1 0
`define MIC_B_PNE1 1
`define MIC_B_I2CE 2
`define MIC_B_TBF1 4
`define MIC_B_PNF1 5
`define MIC_B_I2CF 6
`define MIC_B_PE 0
`define MIC_B_AE 1
`define MIC_B_PF 4
`define MIC_B_AF 5
`define MIC_B_CPE 2
`define MIC_B_CAE 3
`define MIC_B_CPF 6
`define MIC_B_CAF 7
`define MIC_B_SEL0 0
`define MIC_B_DIN0 2
`define MIC_EV_TB0 0
`define MIC_EV_TB1 1
`define MIC_EV_ADC 2
`define MIC_EV_I2C 3
`define MIC_EV_STA 4
`define MIC_EV_STP 5
`define MIC_EV_CTA 6
`define MIC_EV_CTP 7
`define MIC_EV_PTA 8
`define MIC_EV_PTP 9
`define MIC_EV_EE 10
`define MIC_EV_LV 11
`define MIC_V_EXT0 4'h0
`define MIC_V_MF0 4'h1
`define MIC_V_MF1 4'h2
`define MIC_V_MF2 4'h3
`define MIC_V_ADC 4'h4
`define MIC_V_TB0 4'h5
`define MIC_V_TB1 4'h6
`define MIC_V_I2C 4'h7
`define MIC_V_EXT1 4'h8
`define MIC_RESP_OK 2'h0
`define MIC_RESP_ERR 2'h2
`endif

// *** design/mic_pkg.sv ***
/*
 Types of the interrupt controller: state encoding and the
 packed state record. Assumes mic_consts.svh on the path.
*/
`include "mic_consts.svh"
package mic_pkg;
   typedef enum logic [1:0] {
      MIC_RUN  = 2'b01,
      MIC_VECT = 2'b10
   } mic_state_t;
   typedef logic [7:0][7:0] mic_regs_t;
   typedef struct packed {
      mic_state_t             fsm;
      mic_regs_t              regs;
      logic [1:0]             pin;
      logic [2:0]             mreq;
      logic                   aw_have;
      logic [7:0]             aw_addr;
      logic                   w_have;
      logic [7:0]             wdata;
      logic                   wstrb0;
      logic                   awready;
      logic                   wready;
      logic                   bvalid;
      logic [1:0]             bresp;
      logic                   arready;
      logic                   rvalid;
      logic [7:0]             rdata;
      logic [1:0]             rresp;
      logic                   take;
      logic [3:0]             vec;
      logic [`MIC_PCW-1:0]    push_pc;
      logic                   pop;
      logic                   wake;
   } mic_st_t;
endpackage

// *** design/mic_intc.sv ***
/*
 Interrupt controller with AXI4-Lite register slave, request
 flags, shared interrupts, vectoring, wake-up.
 Assumes: events are one-cycle pulses, pins synchronous to
 aclk, CPU supplies next PC and stack-full state.
*/
// The AXI4-Lite interface to the registers and the register offsets are this design's own decisions.
// Functional notes
// - Control 2 holds i2c, pin1, timebase1 flags/enables
// - Shared source 0 holds standard timer matches
// - Shared source 1 holds compact, periodic matches
// - Shared source 2 holds eeprom, low voltage
// - Unimplemented bits read zero, except control 0 bits 2, 5 and control 2 bits 3, 7; reset clears all
// - Source event sets flag regardless of enables
// - Disabled flag stays set, no vector
// - Global enable low blocks every interrupt
// - Take pushes next PC, loads vector
// - Return instruction pops saved PC
// - Taking interrupt clears global enable
// - Blocked requests keep flags for later
// - Full stack holds off any request
// - Newly set flag wakes from sleep
// - Pin flag set on selected edge
// - Edge field: off, rise, fall, both
// - Pin needs enable, function select, input
// - Servicing pin clears its flag
// - Three shared interrupts fed by members
// - Enabled member request sets shared flag when none was pending
// - Service clears shared flag, members stay
// - Global enable is control 0 bit 0
`timescale 1ns/1ns
`include "mic_consts.svh"
module mic_intc
   import mic_pkg::*;
(
   input  wire logic                  aclk,          // Clock
   input  wire logic                  aresetn,       // Reset
   input  wire logic [7:0]            s_axi_awaddr,  // Wr addr
   input  wire logic                  s_axi_awvalid, // Wr addr vld
   output logic                       s_axi_awready, // Wr addr rdy
   input  wire logic [31:0]           s_axi_wdata,   // Wr data
   input  wire logic [3:0]            s_axi_wstrb,   // Byte enables
   input  wire logic                  s_axi_wvalid,  // Wr data vld
   output logic                       s_axi_wready,  // Wr data rdy
   output logic [1:0]                 s_axi_bresp,   // Wr response
   output logic                       s_axi_bvalid,  // Wr resp vld
   input  wire logic                  s_axi_bready,  // Wr resp rdy
   input  wire logic [7:0]            s_axi_araddr,  // Rd addr
   input  wire logic                  s_axi_arvalid, // Rd addr vld
   output logic                       s_axi_arready, // Rd addr rdy
   output logic [31:0]                s_axi_rdata,   // Rd data
   output logic [1:0]                 s_axi_rresp,   // Rd response
   output logic                       s_axi_rvalid,  // Rd data vld
   input  wire logic                  s_axi_rready,  // Rd data rdy
   input  wire logic [`MIC_NEV-1:0]   src_event,     // Event pulses
   input  wire logic                  ext_int_pin0,  // Pin 0
   input  wire logic                  ext_int_pin1,  // Pin 1
   input  wire logic [`MIC_PCW-1:0]   next_pc,       // PC to save
   input  wire logic                  stack_full,    // Stack full
   input  wire logic                  return_from_interrupt, // Ret
   input  wire logic                  sleep_mode,    // Sleep/idle
   output logic                       int_take,      // Take pulse
   output logic [3:0]                 int_vector,    // Vector index
   output logic [`MIC_PCW-1:0]        pc_push_data,  // PC to push
   output logic                       pc_push,       // Push pulse
   output logic                       pc_pop,        // Pop pulse
   output logic                       wake_up        // Wake pulse
);
   import mic_pkg::*;

   mic_st_t q;
   mic_st_t d;

   function automatic logic [7:0] wmask(input logic [3:0] i);
      case (i)
         `MIC_R_INTC0: wmask = `MIC_M_INTC0;
         `MIC_R_SHS0,
         `MIC_R_SHS2: wmask = `MIC_M_MFI;
         `MIC_R_EDGE,
         `MIC_R_PCFG: wmask = `MIC_M_LOW;
         default: wmask = `MIC_M_FULL;
      endcase
   endfunction

   function automatic logic valid_addr(input logic [7:0] a);
      valid_addr = (a[7:6] == 2'h0) && (a[5:2] <= `MIC_R_STAT)
         && (a[1:0] == 2'h0);
   endfunction

   // All request flags, for wake-up edge detection
   function automatic logic [16:0] flags(input mic_regs_t r);
      flags = {r[`MIC_R_INTC0][`MIC_B_MF0F],
               r[`MIC_R_INTC0][`MIC_B_INT0F],
               r[`MIC_R_INTC1][7:4],
               r[`MIC_R_CTL2][6:4],
               r[`MIC_R_SHS0][5:4],
               r[`MIC_R_SHS1][7:4],
               r[`MIC_R_SHS2][5:4]};
   endfunction

   function automatic logic [3:0] pick(input logic [8:0] p);
      pick = 4'h0;
      for (int i = 8; i >= 0; i--) begin
         if (p[i]) begin
            pick = 4'(i);
         end
      end
   endfunction

   logic [8:0]        pend;
   logic [2:0]        mreq;
   logic [1:0]        pins;
   logic [1:0]        hit;
   logic              wr;
   logic [3:0]        widx;
   logic [3:0]        ridx;
   logic [7:0]        m;
   logic [1:0]        es;
   logic              act;
   mic_regs_t         r;

   always_comb begin
      d = q;
      r = q.regs;
      d.take = 1'b0;
      d.pop = return_from_interrupt;
      widx = q.aw_addr[5:2];
      ridx = s_axi_araddr[5:2];
      pins = {ext_int_pin1, ext_int_pin0};
      hit = 2'b00;
      m = 8'h00;
      es = 2'b00;
      act = 1'b0;
      // Write channels, taken in either order
      if (s_axi_awvalid && q.awready) begin
         d.aw_have = 1'b1;
         d.aw_addr = s_axi_awaddr;
      end
      if (s_axi_wvalid && q.wready) begin
         d.w_have = 1'b1;
         d.wdata = s_axi_wdata[7:0];
         d.wstrb0 = s_axi_wstrb[0];
      end
      if (q.bvalid && s_axi_bready) begin
         d.bvalid = 1'b0;
      end
      wr = q.aw_have && q.w_have && !q.bvalid;
      if (wr) begin
         d.aw_have = 1'b0;
         d.w_have = 1'b0;
         d.bvalid = 1'b1;
         d.bresp = valid_addr(q.aw_addr) ? `MIC_RESP_OK
                                          : `MIC_RESP_ERR;
         if (valid_addr(q.aw_addr) && q.wstrb0
             && widx != `MIC_R_STAT) begin
            m = wmask(widx);
            // Bits outside the write mask never stored
            d.regs[widx[2:0]] = (q.wdata & m)
                              | (q.regs[widx[2:0]] & ~m);
         end
      end
      d.awready = !d.aw_have;
      d.wready = !d.w_have;
      // Read channel
      if (q.rvalid && s_axi_rready) begin
         d.rvalid = 1'b0;
      end
      if (s_axi_arvalid && q.arready) begin
         d.rvalid = 1'b1;
         d.rresp = `MIC_RESP_ERR;
         d.rdata = 8'h00;
         if (valid_addr(s_axi_araddr)) begin
            d.rresp = `MIC_RESP_OK;
            if (ridx == `MIC_R_STAT) begin
               d.rdata = {2'b00, sleep_mode, stack_full, q.vec};
            end else begin
               d.rdata = q.regs[ridx[2:0]];
            end
         end
      end
      d.arready = !d.rvalid;

      // Pending requests in priority order
      pend[0] = r[`MIC_R_INTC0][`MIC_B_INT0F]
              & r[`MIC_R_INTC0][`MIC_B_INT0E];
      pend[1] = r[`MIC_R_INTC0][`MIC_B_MF0F]
              & r[`MIC_R_INTC0][`MIC_B_MF0E];
      pend[2] = r[`MIC_R_INTC1][`MIC_B_MF1F]
              & r[`MIC_R_INTC1][`MIC_B_MF1E];
      pend[3] = r[`MIC_R_INTC1][`MIC_B_MF2F]
              & r[`MIC_R_INTC1][`MIC_B_MF2E];
      pend[4] = r[`MIC_R_INTC1][`MIC_B_ADF]
              & r[`MIC_R_INTC1][`MIC_B_ADE];
      pend[5] = r[`MIC_R_INTC1][`MIC_B_TB0F]
              & r[`MIC_R_INTC1][`MIC_B_TB0E];
      pend[6] = r[`MIC_R_CTL2][`MIC_B_TBF1]
              & r[`MIC_R_CTL2][`MIC_B_TBE1];
      pend[7] = r[`MIC_R_CTL2][`MIC_B_I2CF]
              & r[`MIC_R_CTL2][`MIC_B_I2CE];
      pend[8] = r[`MIC_R_CTL2][`MIC_B_PNF1]
              & r[`MIC_R_CTL2][`MIC_B_PNE1];

      case (q.fsm)
         MIC_RUN: begin
            // Disabled flags stay pending
            if (r[`MIC_R_INTC0][`MIC_B_GIE]
                && !stack_full
                && (|pend)) begin
               d.take = 1'b1;
               d.vec = pick(pend);
               d.push_pc = next_pc;
               d.fsm = MIC_VECT;
               d.regs[`MIC_R_INTC0][`MIC_B_GIE] = 1'b0;
               case (pick(pend))
                  `MIC_V_EXT0: d.regs[`MIC_R_INTC0][`MIC_B_INT0F]
                     = 1'b0;
                  `MIC_V_MF0: d.regs[`MIC_R_INTC0][`MIC_B_MF0F]
                     = 1'b0;
                  `MIC_V_MF1: d.regs[`MIC_R_INTC1][`MIC_B_MF1F]
                     = 1'b0;
                  `MIC_V_MF2: d.regs[`MIC_R_INTC1][`MIC_B_MF2F]
                     = 1'b0;
                  `MIC_V_ADC: d.regs[`MIC_R_INTC1][`MIC_B_ADF]
                     = 1'b0;
                  `MIC_V_TB0: d.regs[`MIC_R_INTC1][`MIC_B_TB0F]
                     = 1'b0;
                  `MIC_V_TB1: d.regs[`MIC_R_CTL2][`MIC_B_TBF1]
                     = 1'b0;
                  `MIC_V_I2C: d.regs[`MIC_R_CTL2][`MIC_B_I2CF]
                     = 1'b0;
                  default: d.regs[`MIC_R_CTL2][`MIC_B_PNF1]
                     = 1'b0;
               endcase
            end
         end
         MIC_VECT: d.fsm = MIC_RUN; // One vector at a time
         default: d.fsm = MIC_RUN;
      endcase

      // Pin edges; sets come after clears so sets win
      d.pin = pins;
      for (int k = 0; k < 2; k++) begin
         es = q.regs[`MIC_R_EDGE][2*k +: 2];
         act = q.regs[`MIC_R_PCFG][`MIC_B_SEL0 + k]
             & q.regs[`MIC_R_PCFG][`MIC_B_DIN0 + k];
         hit[k] = act & ((es[0] & pins[k] & !q.pin[k])
                       | (es[1] & !pins[k] & q.pin[k]));
      end
      if (hit[0] && r[`MIC_R_INTC0][`MIC_B_INT0E]) begin
         d.regs[`MIC_R_INTC0][`MIC_B_INT0F] = 1'b1;
      end
      if (hit[1] && r[`MIC_R_CTL2][`MIC_B_PNE1]) begin
         d.regs[`MIC_R_CTL2][`MIC_B_PNF1] = 1'b1;
      end

      // Source events set flags whatever the enables
      if (src_event[`MIC_EV_TB0])
         d.regs[`MIC_R_INTC1][`MIC_B_TB0F] = 1'b1;
      if (src_event[`MIC_EV_ADC])
         d.regs[`MIC_R_INTC1][`MIC_B_ADF] = 1'b1;
      if (src_event[`MIC_EV_TB1])
         d.regs[`MIC_R_CTL2][`MIC_B_TBF1] = 1'b1;
      if (src_event[`MIC_EV_I2C])
         d.regs[`MIC_R_CTL2][`MIC_B_I2CF] = 1'b1;
      if (src_event[`MIC_EV_STA])
         d.regs[`MIC_R_SHS0][`MIC_B_AF] = 1'b1;
      if (src_event[`MIC_EV_STP])
         d.regs[`MIC_R_SHS0][`MIC_B_PF] = 1'b1;
      if (src_event[`MIC_EV_CTA])
         d.regs[`MIC_R_SHS1][`MIC_B_CAF] = 1'b1;
      if (src_event[`MIC_EV_CTP])
         d.regs[`MIC_R_SHS1][`MIC_B_CPF] = 1'b1;
      if (src_event[`MIC_EV_PTA])
         d.regs[`MIC_R_SHS1][`MIC_B_AF] = 1'b1;
      if (src_event[`MIC_EV_PTP])
         d.regs[`MIC_R_SHS1][`MIC_B_PF] = 1'b1;
      if (src_event[`MIC_EV_EE])
         d.regs[`MIC_R_SHS2][`MIC_B_AF] = 1'b1;
      if (src_event[`MIC_EV_LV])
         d.regs[`MIC_R_SHS2][`MIC_B_PF] = 1'b1;

      // Enabled member requests feed shared flags
      mreq[0] = |(r[`MIC_R_SHS0][5:4] & r[`MIC_R_SHS0][1:0]);
      mreq[1] = |(r[`MIC_R_SHS1][7:4] & r[`MIC_R_SHS1][3:0]);
      mreq[2] = |(r[`MIC_R_SHS2][5:4] & r[`MIC_R_SHS2][1:0]);
      d.mreq = mreq;
      if (mreq[0] && !q.mreq[0])
         d.regs[`MIC_R_INTC0][`MIC_B_MF0F] = 1'b1;
      if (mreq[1] && !q.mreq[1])
         d.regs[`MIC_R_INTC1][`MIC_B_MF1F] = 1'b1;
      if (mreq[2] && !q.mreq[2])
         d.regs[`MIC_R_INTC1][`MIC_B_MF2F] = 1'b1;

      // Only a flag rising wakes; one already set does not
      d.wake = sleep_mode
             & (|(flags(d.regs) & ~flags(q.regs)));
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         q <= '0; // All flags and enables clear
         q.fsm <= MIC_RUN;
      end else begin
         q <= d;
      end
   end

   assign s_axi_awready = q.awready;
   assign s_axi_wready  = q.wready;
   assign s_axi_bvalid  = q.bvalid;
   assign s_axi_bresp   = q.bresp;
   assign s_axi_arready = q.arready;
   assign s_axi_rvalid  = q.rvalid;
   assign s_axi_rdata   = {24'h000000, q.rdata};
   assign s_axi_rresp   = q.rresp;
   assign int_take      = q.take;
   assign pc_push       = q.take;
   assign int_vector    = q.vec;
   assign pc_push_data  = q.push_pc;
   assign pc_pop        = q.pop;
   assign wake_up       = q.wake;

   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   sequence s_sta_ev;
      src_event[`MIC_EV_STA] && q.regs[`MIC_R_SHS0][`MIC_B_AE]
         && !q.mreq[0];
   endsequence
   sequence s_mf0_set;
      q.regs[`MIC_R_INTC0][`MIC_B_MF0F] || q.take;
   endsequence

   gie_block_a: assert property (
      !q.regs[`MIC_R_INTC0][`MIC_B_GIE] |=> !q.take)
      else $error("interrupt taken with global enable low");
   full_block_a: assert property (
      stack_full |=> !q.take)
      else $error("interrupt taken with stack full");
   take_gie_a: assert property (
      q.take |-> !q.regs[`MIC_R_INTC0][`MIC_B_GIE])
      else $error("global enable not cleared on take");
   push_pc_a: assert property (
      q.take |-> q.push_pc == $past(next_pc))
      else $error("pushed PC differs from next PC");
   one_vector_a: assert property (
      q.take |=> !q.take)
      else $error("two vectors back to back");
   ev_flag_a: assert property (
      src_event[`MIC_EV_TB1] |=> q.regs[`MIC_R_CTL2][`MIC_B_TBF1])
      else $error("event did not set its flag");
   // A software write may clear the flag legally
   off_hold_a: assert property (
      q.regs[`MIC_R_CTL2][`MIC_B_TBF1]
      && !q.regs[`MIC_R_CTL2][`MIC_B_TBE1]
      && !(wr && widx == `MIC_R_CTL2)
      |=> !(q.take && q.vec == `MIC_V_TB1)
          && q.regs[`MIC_R_CTL2][`MIC_B_TBF1])
      else $error("disabled flag vectored or lost");
   wake_cause_a: assert property (
      q.wake |-> $past(sleep_mode))
      else $error("wake-up outside sleep");
   shared_set_a: assert property (
      s_sta_ev |-> ##[1:2] s_mf0_set)
      else $error("shared flag not set by member");
   rsv_zero_a: assert property (
      s_axi_arvalid && q.arready
      && s_axi_araddr == {2'h0, `MIC_R_SHS0, 2'h0}
      |=> q.rvalid && q.rdata[7:6] == 2'h0 && q.rdata[3:2] == 2'h0)
      else $error("reserved bits read non-zero");
   ret_pop_a: assert property (
      return_from_interrupt |=> q.pop)
      else $error("return did not pop");
endmodule

// *** tb/mic_cpu_model.sv ***
/*
 Program sequencer model: return stack of DEPTH entries, saved PC,
 return pulse on request. Assumes push/pop pulses from mic_intc.
*/
`timescale 1ns/1ns
`include "mic_consts.svh"
module mic_cpu_model #(
   parameter int DEPTH = 2
) (
   input  wire logic                 aclk,         // Clock
   input  wire logic                 aresetn,      // Reset
   input  wire logic                 pc_push,      // Push pulse
   input  wire logic [`MIC_PCW-1:0]  pc_push_data, // PC to save
   input  wire logic [3:0]           int_vector,   // Vector index
   input  wire logic                 pc_pop,       // Pop pulse
   input  wire logic                 ret_req,      // Return request
   output logic [`MIC_PCW-1:0]       next_pc,      // Next PC
   output logic                      stack_full,   // Stack full
   output logic                      return_from_interrupt // Ret
);
   logic [`MIC_PCW-1:0] stk_q [DEPTH];
   int unsigned         depth_q;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         depth_q <= 0;
         next_pc <= `MIC_PCW'(16'h0100);
         return_from_interrupt <= 1'b0;
      end else begin
         // Return instruction ends each routine
         return_from_interrupt <= ret_req;
         if (pc_push) begin
            stk_q[depth_q] <= pc_push_data;
            depth_q <= depth_q + 1;
            next_pc <= `MIC_PCW'({int_vector, 2'b00});
         end else if (pc_pop && depth_q != 0) begin
            depth_q <= depth_q - 1;
            next_pc <= stk_q[depth_q-1];
         end
      end
   end

   assign stack_full = (depth_q == DEPTH);
endmodule

// *** tb/mcu_interrupt_controller_tb.sv ***
/*
 Self-checking bench of mic_intc with a sequencer model.
 Assumes mic_pkg, mic_consts.svh and mic_cpu_model compiled first.
*/
`timescale 1ns/1ns
`include "mic_consts.svh"
module mcu_interrupt_controller_tb;
   logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid;
   logic s_axi_wready, s_axi_bvalid, s_axi_bready, s_axi_arvalid;
   logic s_axi_arready, s_axi_rvalid, s_axi_rready, ext_int_pin0;
   logic ext_int_pin1, stack_full, ret_in, sleep_mode, int_take;
   logic pc_push, pc_pop, wake_up, ret_req;
   logic [7:0] s_axi_awaddr, s_axi_araddr;
   logic [31:0] s_axi_wdata, s_axi_rdata;
   logic [3:0] s_axi_wstrb, int_vector, tvec;
   logic [1:0] s_axi_bresp, s_axi_rresp;
   logic [`MIC_NEV-1:0] src_event;
   logic [`MIC_PCW-1:0] next_pc, pc_push_data, tpc, cur_pc;
   logic [`MIC_PCW-1:0] pcs [$];
   int mismatches, comparisons, takes, base, pops, wakes;

   mic_intc dut_u (.aclk(aclk), .aresetn(aresetn),
      .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
      .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
      .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
      .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
      .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
      .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
      .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
      .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
      .s_axi_rready(s_axi_rready), .src_event(src_event),
      .ext_int_pin0(ext_int_pin0), .ext_int_pin1(ext_int_pin1),
      .next_pc(next_pc), .stack_full(stack_full),
      .return_from_interrupt(ret_in), .sleep_mode(sleep_mode),
      .int_take(int_take), .int_vector(int_vector),
      .pc_push_data(pc_push_data), .pc_push(pc_push),
      .pc_pop(pc_pop), .wake_up(wake_up));

   mic_cpu_model #(.DEPTH(2)) cpu_u (.aclk(aclk), .aresetn(aresetn),
      .pc_push(pc_push), .pc_push_data(pc_push_data),
      .int_vector(int_vector), .pc_pop(pc_pop), .ret_req(ret_req),
      .next_pc(next_pc), .stack_full(stack_full),
      .return_from_interrupt(ret_in));

   initial begin
      aclk = 1'b0;
      forever #10 aclk = ~aclk;
   end

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp) begin
         mismatches++;
         $display("Error at %0t: saw %h, expected %h", $time, seen, exp);
      end
   endtask

   task automatic wrap_up();
      $display("checks %0d, mismatches %0d", comparisons, mismatches);
      if (mismatches == 0 && comparisons > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask

   // Takes, pops and wake pulses as seen at the clock
   always @(posedge aclk) begin
      if (int_take === 1'b1) begin
         takes++;
         tvec = int_vector;
         tpc = pc_push_data;
         chk(32'(pc_push), 32'h1);
      end
      if (pc_pop === 1'b1) pops++;
      if (wake_up === 1'b1) wakes++;
   end

   task automatic wr(input logic [7:0] a, input logic [7:0] d,
                     input logic [1:0] er = `MIC_RESP_OK);
      logic aw, w;
      aw = 1'b0;
      w = 1'b0;
      s_axi_awaddr <= a;
      s_axi_awvalid <= 1'b1;
      s_axi_wdata <= {24'h000000, d};
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      while (!(aw && w)) begin
         @(posedge aclk);
         if (!aw && s_axi_awready === 1'b1) begin
            aw = 1'b1;
            s_axi_awvalid <= 1'b0;
         end
         if (!w && s_axi_wready === 1'b1) begin
            w = 1'b1;
            s_axi_wvalid <= 1'b0;
         end
      end
      do @(posedge aclk); while (s_axi_bvalid !== 1'b1);
      chk(32'(s_axi_bresp), 32'(er));
   endtask

   task automatic rd(input logic [7:0] a, input logic [7:0] e,
                     input logic [1:0] er = `MIC_RESP_OK);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do @(posedge aclk); while (s_axi_arready !== 1'b1);
      s_axi_arvalid <= 1'b0;
      do @(posedge aclk); while (s_axi_rvalid !== 1'b1);
      chk(s_axi_rdata, {24'h000000, e});
      chk(32'(s_axi_rresp), 32'(er));
   endtask

   task automatic pulse(input logic [`MIC_NEV-1:0] m);
      src_event <= m;
      @(posedge aclk);
      src_event <= '0;
      @(posedge aclk);
   endtask

   task automatic pins(input logic v);
      ext_int_pin0 <= v;
      ext_int_pin1 <= v;
      repeat (3) @(posedge aclk);
   endtask

   task automatic expect_take(input logic [3:0] v);
      repeat (20) if (takes == base) @(posedge aclk);
      chk(32'(takes), 32'(base + 1));
      base = takes;
      chk(32'(tvec), 32'(v));
      chk(32'(tpc), 32'(cur_pc));
      pcs.push_back(cur_pc);
      cur_pc = `MIC_PCW'({v, 2'b00});
   endtask

   task automatic no_take();
      repeat (10) @(posedge aclk);
      chk(32'(takes), 32'(base));
   endtask

   task automatic ret(input bit chkpc = 1'b1);
      int n;
      n = pops;
      ret_req <= 1'b1;
      @(posedge aclk);
      ret_req <= 1'b0;
      repeat (4) @(posedge aclk);
      chk(32'(pops), 32'(n + 1));
      cur_pc = pcs.pop_back();
      if (chkpc) chk(32'(next_pc), 32'(cur_pc));
   endtask

   task automatic t_regs();
      logic [7:0] rb [4] = '{8'hff, 8'h33, 8'hff, 8'h33};
      for (int i = 0; i < 8; i++) rd(8'(4 * i), 8'h00);
      for (int i = 0; i < 4; i++) begin
         wr(8'(8 + 4 * i), 8'hff);
         rd(8'(8 + 4 * i), rb[i]);
         wr(8'(8 + 4 * i), 8'h00);
      end
      wr(8'h00, 8'h00);
      wr(8'h04, 8'h00);
      rd(8'h40, 8'h00, `MIC_RESP_ERR);
      wr(8'h44, 8'hff, `MIC_RESP_ERR);
      $display("register test done");
   endtask

   task automatic t_shared();
      int en_b [8] = '{1, 0, 3, 2, 1, 0, 1, 0};
      int g;
      logic [7:0] a, sa, e;
      for (int i = 0; i < 8; i++) begin
         g = (i < 2) ? 0 : ((i < 6) ? 1 : 2);
         a = 8'(12 + 4 * g);
         sa = (g == 0) ? 8'h00 : 8'h04;
         e = 8'(1 << en_b[i]);
         wr(a, e);
         pulse(`MIC_NEV'(1) << (i + 4));
         rd(a, e | 8'(e << 4));
         rd(sa, (g == 0) ? 8'h40 : 8'(8'h08 << g));
         wr(a, 8'h00);
         wr(sa, 8'h00);
      end
      wr(8'h0c, 8'h02);
      wr(8'h00, 8'h09);
      pulse(`MIC_NEV'(1) << `MIC_EV_STA);
      expect_take(`MIC_V_MF0);
      rd(8'h0c, 8'h22);
      rd(8'h00, 8'h08);
      ret();
      wr(8'h0c, 8'h00);
      wr(8'h00, 8'h00);
      $display("shared test done");
   endtask

   task automatic t_nest();
      wr(8'h04, 8'h08);
      wr(8'h08, 8'h05);
      pulse(`MIC_NEV'(12'h00b));
      no_take();
      wr(8'h00, 8'h01);
      expect_take(`MIC_V_TB0);
      rd(8'h00, 8'h00);
      rd(8'h04, 8'h08);
      // Re-enable inside the routine to nest
      wr(8'h00, 8'h01);
      expect_take(`MIC_V_TB1);
      wr(8'h00, 8'h01);
      no_take();
      rd(8'h20, 8'h16);
      rd(8'h08, 8'h45);
      ret(1'b0);
      expect_take(`MIC_V_I2C);
      ret();
      ret();
      wr(8'h04, 8'h00);
      wr(8'h08, 8'h00);
      $display("nesting test done");
   endtask

   task automatic t_pins();
      logic [1:0] m;
      wr(8'h1c, 8'h0f);
      wr(8'h00, 8'h02);
      wr(8'h08, 8'h02);
      for (int i = 0; i < 4; i++) begin
         m = 2'(i);
         wr(8'h18, {4'h0, m, m});
         pins(1'b1);
         rd(8'h00, {3'b000, m[0], 4'h2});
         rd(8'h08, {2'b00, m[0], 5'h02});
         wr(8'h00, 8'h02);
         wr(8'h08, 8'h02);
         pins(1'b0);
         rd(8'h00, {3'b000, m[1], 4'h2});
         rd(8'h08, {2'b00, m[1], 5'h02});
         wr(8'h00, 8'h02);
         wr(8'h08, 8'h02);
      end
      wr(8'h1c, 8'h0c);
      pins(1'b1);
      rd(8'h00, 8'h02);
      pins(1'b0);
      wr(8'h1c, 8'h0f);
      wr(8'h18, 8'h05);
      wr(8'h00, 8'h03);
      pins(1'b1);
      expect_take(`MIC_V_EXT0);
      rd(8'h00, 8'h02);
      rd(8'h08, 8'h22);
      ret();
      wr(8'h00, 8'h00);
      wr(8'h08, 8'h00);
      pins(1'b0);
      $display("pin test done");
   endtask

   task automatic t_wake();
      int n;
      n = wakes;
      sleep_mode <= 1'b1;
      pulse(`MIC_NEV'(1) << `MIC_EV_TB1);
      repeat (3) @(posedge aclk);
      chk(32'(wakes), 32'(n + 1));
      pulse(`MIC_NEV'(1) << `MIC_EV_TB1);
      repeat (3) @(posedge aclk);
      chk(32'(wakes), 32'(n + 1));
      sleep_mode <= 1'b0;
      wr(8'h08, 8'h00);
      $display("wake test done");
   endtask

   initial begin
      {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = '0;
      {s_axi_arvalid, s_axi_rready, ext_int_pin0, ext_int_pin1} = '0;
      {sleep_mode, ret_req, s_axi_awaddr, s_axi_araddr} = '0;
      s_axi_wdata = '0;
      s_axi_wstrb = 4'hf;
      src_event = '0;
      cur_pc = `MIC_PCW'(16'h0100);
      repeat (4) @(posedge aclk);
      aresetn <= 1'b1;
      repeat (2) @(posedge aclk);
      t_regs();
      t_shared();
      t_nest();
      t_pins();
      t_wake();
      wrap_up();
   end

   initial begin
      repeat (20000) @(posedge aclk);
      mismatches++;
      wrap_up();
   end
endmodule
